/* File: rtl/fsc_top.sv */
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`include "fsc_consts.svh"


module fsc_top import fsc_pkg::*; #(
    parameter int ERASE_CYCLES = `FSC_ERASE_MIN_MS * `FSC_CLK_KHZ
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    output logic [14:0] FLASH_ADDR,
    output logic [7:0] FLASH_WDATA,
    output logic FLASH_RD,
    output logic FLASH_WRITE,
    output logic FLASH_PREPROG,
    output logic FLASH_ERASE,
    input wire logic [7:0] FLASH_RDATA,
    input wire logic FLASH_DONE,
    input wire logic FLASH_FAIL
);

    localparam logic [21:0] ERASE_LOAD = 22'(ERASE_CYCLES - 1);
    // bus pipeline
    logic d_act;
    logic d_wr;
    logic [15:0] d_idx;
    logic a_phase;
    logic [7:0] wb;
    // flash control
    fsc_unlock_t unlock;
    logic page_en;
    logic prog_en;
    logic pre_en;
    logic ers_en;
    logic prog_err;
    logic armed;
    logic [14:0] xaddr;
    // crc
    logic [15:0] crc;
    logic [15:0] crc_folded;
    logic [7:0] crc_feed;
    logic byte_select_alias;
    logic crc_val;
    logic [6:0] first_sector;
    logic [6:0] sector_span;
    logic rd_valid;
    // sequencer
    fsc_seq_t seq;
    logic [21:0] ecnt;
    logic [2:0] esub;
    logic [14:0] run_addr;
    logic [14:0] run_end;
    logic [7:0] span_sum;
    logic [6:0] end_sector;
    logic run_done;
    logic key_wr;
    logic ctrl_wr;
    logic xa_wr;
    logic xd_wr;
    logic din_wr;
    logic cr_wr;
    logic dr_wr;
    logic beg_wr;
    logic cnt_wr;
    logic launch;
    logic do_erase;
    logic do_pre;
    logic do_write;
    function automatic logic wr_hit(input logic [15:0] want);
        return d_act & d_wr & (d_idx == want);
    endfunction
    // only writes that can start a long operation take the wait state
    function automatic logic stall_target(input logic [15:0] idx);
        return (idx == `FSC_IDX_XDATA) || (idx == `FSC_IDX_CR);
    endfunction
    assign a_phase = HSEL & HTRANS[1] & HREADY;
    assign wb = HWDATA[7:0];
    assign key_wr = wr_hit(`FSC_IDX_KEY);
    assign ctrl_wr = wr_hit(`FSC_IDX_CTRL);
    assign xa_wr = wr_hit(`FSC_IDX_XADDR);
    assign xd_wr = wr_hit(`FSC_IDX_XDATA);
    assign din_wr = wr_hit(`FSC_IDX_DIN);
    assign cr_wr = wr_hit(`FSC_IDX_CR);
    assign dr_wr = wr_hit(`FSC_IDX_DR);
    assign beg_wr = wr_hit(`FSC_IDX_BEG);
    assign cnt_wr = wr_hit(`FSC_IDX_CNT);
    assign launch = cr_wr & wb[`FSC_B_LAUNCH];
    // an operation runs only if armed by a control write made while released
    assign do_erase = xd_wr & armed & prog_en & ers_en & page_en;
    assign do_pre = xd_wr & armed & prog_en & pre_en & ~ers_en & page_en;
    assign do_write = xd_wr & armed & prog_en & ~ers_en & ~pre_en;
    assign span_sum = {1'b0, first_sector} + {1'b0, sector_span};
    assign end_sector = (span_sum > `FSC_LAST_SECTOR_W) ? `FSC_LAST_SECTOR
                                                        : span_sum[6:0];
    assign run_done = (seq != FSC_SEQ_RUN) && (seq != FSC_SEQ_RUN_TAIL);
    assign crc_feed = rd_valid ? FLASH_RDATA : wb;
    fsc_crc_byte u_crc (
        .crc_in(crc),
        .data(crc_feed),
        .crc_out(crc_folded)
    );
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            d_act <= 1'b0;
            d_wr <= 1'b0;
            d_idx <= 16'h0000;
        end else begin
            d_act <= a_phase;
            if (a_phase) begin
                d_wr <= HWRITE;
                d_idx <= HADDR[17:2];
            end
        end
    end

    function automatic logic [31:0] rd_word(input logic [15:0] idx);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (idx)
            `FSC_IDX_CTRL: r[5:0] = {page_en, prog_err, 1'b0, pre_en, ers_en, prog_en};
            `FSC_IDX_STATE: r[1:0] = unlock;
            `FSC_IDX_XADDR: r[14:0] = xaddr;
            `FSC_IDX_CR: r[4:0] = {run_done, 1'b0, crc_val, 1'b0, byte_select_alias};
            `FSC_IDX_DR: r[7:0] = byte_select_alias ? crc[15:8] : crc[7:0];
            `FSC_IDX_BEG: r[6:0] = first_sector;
            `FSC_IDX_CNT: r[6:0] = sector_span;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            if (a_phase && !HWRITE) begin
                HRDATA <= rd_word(HADDR[17:2]);
            end
        end
    end
    // key sequence state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            unlock <= FSC_UNL_LOCKED;
        end else if (key_wr) begin
            unique case (unlock)
                FSC_UNL_LOCKED: unlock <= (wb == `FSC_KEY_FIRST) ? FSC_UNL_WAIT2
                                                                 : FSC_UNL_FROZEN;
                FSC_UNL_WAIT2: unlock <= (wb == `FSC_KEY_SECOND) ? FSC_UNL_RELEASED
                                                                 : FSC_UNL_FROZEN;
                FSC_UNL_FROZEN: unlock <= FSC_UNL_FROZEN;
                FSC_UNL_RELEASED: unlock <= FSC_UNL_FROZEN;
            endcase
        end else if (ctrl_wr && unlock == FSC_UNL_RELEASED) begin
            unlock <= FSC_UNL_LOCKED;
        end
    end
    // control bits, arming and error flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            page_en <= 1'b0;
            prog_en <= 1'b0;
            pre_en <= 1'b0;
            ers_en <= 1'b0;
            armed <= 1'b0;
        end else if (ctrl_wr) begin
            page_en <= wb[`FSC_B_PAGE];
            prog_en <= wb[`FSC_B_EN];
            pre_en <= wb[`FSC_B_PRE];
            ers_en <= wb[`FSC_B_ERS];
            armed <= (unlock == FSC_UNL_RELEASED);
        end else if (seq == FSC_SEQ_FINISH) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prog_err <= 1'b0;
        end else if (seq == FSC_SEQ_PROG_WAIT && FLASH_DONE) begin
            prog_err <= FLASH_FAIL;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            xaddr <= 15'h0000;
        end else if (xa_wr) begin
            xaddr <= HWDATA[14:0];
        end
    end

    // crc control and sector range
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            byte_select_alias <= 1'b0;
            crc_val <= 1'b0;
            first_sector <= 7'h00;
            sector_span <= 7'h00;
        end else begin
            if (cr_wr) begin
                byte_select_alias <= wb[`FSC_B_PNT];
                crc_val <= wb[`FSC_B_VAL];
            end
            if (beg_wr) begin
                first_sector <= wb[6:0];
            end
            if (cnt_wr) begin
                sector_span <= wb[6:0];
            end
        end
    end

    // running result; the bus is stalled during a run, so sources never collide
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            crc <= `FSC_CRC_ZERO;
        end else if (cr_wr && wb[`FSC_B_INIT]) begin
            crc <= wb[`FSC_B_VAL] ? `FSC_CRC_ONES : `FSC_CRC_ZERO;
        end else if (dr_wr) begin
            if (byte_select_alias) begin
                crc[15:8] <= wb;
            end else begin
                crc[7:0] <= wb;
            end
        end else if (din_wr || rd_valid) begin
            crc <= crc_folded;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= FLASH_RD;
        end
    end

    // sequencer: flash operations, sector runs and the bus wait state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            seq <= FSC_SEQ_IDLE;
            HREADYOUT <= 1'b1;
            FLASH_ADDR <= 15'h0000;
            FLASH_WDATA <= 8'h00;
            FLASH_RD <= 1'b0;
            FLASH_WRITE <= 1'b0;
            FLASH_PREPROG <= 1'b0;
            FLASH_ERASE <= 1'b0;
            ecnt <= 22'h000000;
            esub <= 3'h0;
            run_addr <= 15'h0000;
            run_end <= 15'h0000;
        end else begin
            FLASH_WRITE <= 1'b0;
            FLASH_PREPROG <= 1'b0;
            FLASH_ERASE <= 1'b0;
            FLASH_RD <= 1'b0;
            unique case (seq)
                FSC_SEQ_IDLE: begin
                    HREADYOUT <= !(a_phase && HWRITE && stall_target(HADDR[17:2]));
                    if (do_erase) begin
                        HREADYOUT <= 1'b0;
                        esub <= 3'h0;
                        seq <= FSC_SEQ_ERASE;
                    end else if (do_pre) begin
                        HREADYOUT <= 1'b0;
                        FLASH_ADDR <= {xaddr[14:11], `FSC_PAGE_BASE};
                        FLASH_PREPROG <= 1'b1;
                        seq <= FSC_SEQ_PROG_WAIT;
                    end else if (do_write) begin
                        HREADYOUT <= 1'b0;
                        FLASH_ADDR <= xaddr;
                        FLASH_WDATA <= wb;
                        FLASH_WRITE <= 1'b1;
                        seq <= FSC_SEQ_PROG_WAIT;
                    end else if (launch) begin
                        HREADYOUT <= 1'b0;
                        run_addr <= {first_sector, `FSC_SECTOR_BASE};
                        run_end <= {end_sector, `FSC_SECTOR_TOP};
                        seq <= FSC_SEQ_RUN;
                    end
                end
                FSC_SEQ_ERASE: begin
                    // a page goes sector by sector so the device's last sector, 7f, can be skipped
                    FLASH_ADDR <= {xaddr[14:11], esub, `FSC_SECTOR_BASE};
                    FLASH_ERASE <= ({xaddr[14:11], esub} != `FSC_LAST_SECTOR);
                    esub <= esub + 3'h1;
                    if (esub == `FSC_LAST_SUB) begin
                        ecnt <= ERASE_LOAD;
                        seq <= FSC_SEQ_ERASE_WAIT;
                    end
                end
                FSC_SEQ_ERASE_WAIT: begin
                    ecnt <= ecnt - 22'h000001;
                    if (ecnt == 22'h000000) begin
                        seq <= FSC_SEQ_FINISH;
                    end
                end
                FSC_SEQ_PROG_WAIT: begin
                    if (FLASH_DONE) begin
                        seq <= FSC_SEQ_FINISH;
                    end
                end
                FSC_SEQ_RUN: begin
                    FLASH_RD <= 1'b1;
                    FLASH_ADDR <= run_addr;
                    run_addr <= run_addr + 15'h0001;
                    if (run_addr == run_end) begin
                        seq <= FSC_SEQ_RUN_TAIL;
                    end
                end
                FSC_SEQ_RUN_TAIL: begin
                    // last byte still in flight from the array
                    seq <= FSC_SEQ_FINISH;
                end
                FSC_SEQ_FINISH: begin
                    HREADYOUT <= 1'b1;
                    seq <= FSC_SEQ_IDLE;
                end
                default: begin
                    HREADYOUT <= 1'b1;
                    seq <= FSC_SEQ_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: rtl/fsc_consts.svh */
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define FSC_IDX_KEY 16'h0084
`define FSC_IDX_CTRL 16'h0085
`define FSC_IDX_STATE 16'h0086
`define FSC_IDX_XADDR 16'h0088
`define FSC_IDX_XDATA 16'h0089
`define FSC_IDX_DIN 16'h4021
`define FSC_IDX_CR 16'h4022
`define FSC_IDX_DR 16'h4023
`define FSC_IDX_BEG 16'h4024
`define FSC_IDX_CNT 16'h4025

// flash control bits
`define FSC_B_EN 0
`define FSC_B_ERS 1
`define FSC_B_PRE 2
`define FSC_B_ERR 4
`define FSC_B_PAGE 5

// crc control bits
`define FSC_B_PNT 0
`define FSC_B_LAUNCH 1
`define FSC_B_VAL 2
`define FSC_B_INIT 3
`define FSC_B_DONE 4

`define FSC_KEY_FIRST 8'h5a
`define FSC_KEY_SECOND 8'h1f
`define FSC_CRC_POLY 16'h1021
`define FSC_CRC_ZERO 16'h0000
`define FSC_CRC_ONES 16'hffff
`define FSC_LAST_SECTOR 7'h7f
`define FSC_LAST_SECTOR_W 8'h7f
`define FSC_SECTOR_TOP 8'hff
`define FSC_SECTOR_BASE 8'h00
`define FSC_PAGE_BASE 11'h000
`define FSC_LAST_SUB 3'h7

// timing
`define FSC_CLK_KHZ 25000
`define FSC_ERASE_MIN_MS 120

`endif

/* File: rtl/fsc_pkg.sv */
package fsc_pkg;

    typedef enum logic [1:0] {
        FSC_UNL_LOCKED = 2'b00,
        FSC_UNL_WAIT2 = 2'b01,
        FSC_UNL_FROZEN = 2'b10,
        FSC_UNL_RELEASED = 2'b11
    } fsc_unlock_t;

    typedef enum logic [2:0] {
        FSC_SEQ_IDLE = 3'b000,
        FSC_SEQ_ERASE = 3'b001,
        FSC_SEQ_ERASE_WAIT = 3'b010,
        FSC_SEQ_PROG_WAIT = 3'b011,
        FSC_SEQ_RUN = 3'b100,
        FSC_SEQ_RUN_TAIL = 3'b101,
        FSC_SEQ_FINISH = 3'b110
    } fsc_seq_t;

endpackage

/* File: rtl/fsc_crc_byte.sv */
`timescale 1ns/100ps
`include "fsc_consts.svh"

module fsc_crc_byte import fsc_pkg::*; (
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);

    // whole byte folded in one combinational pass, msb first, no reflection
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0} ^ (fb ? `FSC_CRC_POLY : `FSC_CRC_ZERO);
        end
        return r;
    endfunction

    assign crc_out = fold(crc_in, data);

endmodule

/* File: verif/fsc_top_monitor.sv */
`timescale 1ns/100ps
module fsc_top_monitor #(
    parameter int ERASE_CYCLES = 20
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic [14:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_WDATA,
    input wire logic FLASH_RD,
    input wire logic FLASH_WRITE,
    input wire logic FLASH_PREPROG,
    input wire logic FLASH_ERASE,
    input wire logic [7:0] FLASH_RDATA,
    input wire logic FLASH_DONE,
    input wire logic FLASH_FAIL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    int since_erase;
    logic erase_seen;
    // erase time is measured from the last sector pulse to the bus release
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            since_erase <= 0;
            erase_seen <= 1'b0;
        end else begin
            since_erase <= FLASH_ERASE ? 0 : since_erase + 1;
            erase_seen <= FLASH_ERASE | (erase_seen & ~HREADYOUT);
        end
    end
    okay_resp_a: assert property (HRESP == 1'b0) else $error("response not okay");
    one_strobe_a: assert property ($onehot0({FLASH_WRITE, FLASH_PREPROG, FLASH_ERASE, FLASH_RD}))
        else $error("two flash strobes at once");
    last_sector_a: assert property (FLASH_ERASE |-> FLASH_ADDR[14:8] != 7'h7f)
        else $error("last sector erased");
    erase_align_a: assert property (FLASH_ERASE |-> FLASH_ADDR[7:0] == 8'h00)
        else $error("erase not sector aligned");
    pre_page_a: assert property (FLASH_PREPROG |-> FLASH_ADDR[10:0] == 11'h000)
        else $error("pre-program not page aligned");
    write_stall_a: assert property (FLASH_WRITE |-> !HREADYOUT [*2])
        else $error("bus released during write");
    run_stall_a: assert property (FLASH_RD |-> !HREADYOUT) else $error("run not stalled");
    run_step_a: assert property (FLASH_RD && $past(FLASH_RD) |->
        FLASH_ADDR == $past(FLASH_ADDR) + 15'h0001) else $error("run address skipped");
    run_start_a: assert property ($rose(FLASH_RD) |-> FLASH_ADDR[7:0] == 8'h00)
        else $error("run not at sector start");
    run_clip_a: assert property (FLASH_RD && FLASH_ADDR == 15'h7fff |=> !FLASH_RD)
        else $error("run passed last sector");
    read_nowait_a: assert property (HSEL && HTRANS[1] && HREADY && !HWRITE |=> HREADYOUT)
        else $error("read took wait states");
    erase_time_a: assert property ($rose(HREADYOUT) && erase_seen |->
        since_erase >= ERASE_CYCLES) else $error("erase reported too early");
endmodule
bind fsc_top fsc_top_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) i_mon (.CLK(CLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_WDATA(FLASH_WDATA), .FLASH_RD(FLASH_RD),
    .FLASH_WRITE(FLASH_WRITE), .FLASH_PREPROG(FLASH_PREPROG), .FLASH_ERASE(FLASH_ERASE),
    .FLASH_RDATA(FLASH_RDATA), .FLASH_DONE(FLASH_DONE), .FLASH_FAIL(FLASH_FAIL));

/* File: verif/fsc_flash_model.sv */
`timescale 1ns/100ps
module fsc_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [14:0] addr,
    input wire logic [7:0] wdata,
    input wire logic rd,
    input wire logic wr,
    input wire logic pre,
    input wire logic ers,
    input wire logic fail_req,
    input wire logic slow,
    output logic [7:0] rdata,
    output logic done,
    output logic fail
);
    int wr_cnt;
    int pre_cnt;
    int ers_cnt;
    int wait_cnt;
    logic [14:0] last_addr;
    logic [7:0] last_data;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            done <= 1'b0;
            fail <= 1'b0;
            wait_cnt <= 0;
            wr_cnt <= 0;
            pre_cnt <= 0;
            ers_cnt <= 0;
        end else begin
            // idle read bus toggles so a stale byte never looks valid
            rdata <= rd ? (addr[7:0] ^ {addr[14:8], 1'b1}) : ~rdata;
            done <= (wait_cnt == 1);
            fail <= (wait_cnt == 1) ? fail_req : ~fail;
            if (wr || pre) begin
                wait_cnt <= slow ? 9 : 1;
                last_addr <= addr;
                last_data <= wdata;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end
            wr_cnt <= wr_cnt + int'(wr);
            pre_cnt <= pre_cnt + int'(pre);
            ers_cnt <= ers_cnt + int'(ers);
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
`include "fsc_consts.svh"
module tb_top;
    localparam int ERASE_N = 20;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'b00;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic HREADYOUT, HRESP, FLASH_RD, FLASH_WRITE, FLASH_PREPROG, FLASH_ERASE;
    logic [31:0] HRDATA;
    logic [14:0] FLASH_ADDR;
    logic [7:0] FLASH_WDATA, FLASH_RDATA;
    logic FLASH_DONE, FLASH_FAIL;
    logic fail_req = 1'b0;
    logic slow = 1'b0;
    logic [31:0] r;
    logic [15:0] e;
    logic [14:0] a;
    int w, failures = 0, comparisons = 0, cycles = 0, seed;
    logic [6:0] beg_t[3] = '{7'h7e, 7'h03, 7'h7f};
    logic [6:0] cnt_t[3] = '{7'h05, 7'h00, 7'h10};
    always #20 CLK = ~CLK;
    fsc_top #(.ERASE_CYCLES(ERASE_N)) i_dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .FLASH_ADDR(FLASH_ADDR),
        .FLASH_WDATA(FLASH_WDATA), .FLASH_RD(FLASH_RD), .FLASH_WRITE(FLASH_WRITE),
        .FLASH_PREPROG(FLASH_PREPROG), .FLASH_ERASE(FLASH_ERASE), .FLASH_RDATA(FLASH_RDATA),
        .FLASH_DONE(FLASH_DONE), .FLASH_FAIL(FLASH_FAIL));
    fsc_flash_model i_flash (.clk(CLK), .rst(RST), .addr(FLASH_ADDR), .wdata(FLASH_WDATA),
        .rd(FLASH_RD), .wr(FLASH_WRITE), .pre(FLASH_PREPROG), .ers(FLASH_ERASE),
        .fail_req(fail_req), .slow(slow), .rdata(FLASH_RDATA), .done(FLASH_DONE),
        .fail(FLASH_FAIL));
    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
        end
        return c;
    endfunction
    task automatic conclude();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= wr;
        HADDR <= {14'h0, idx, 2'b00};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= wd;
        w = 0;
        do begin
            @(posedge CLK);
            w++;
        end while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic unlock();
        bus(1'b1, `FSC_IDX_KEY, 32'h5a);
        bus(1'b1, `FSC_IDX_KEY, 32'h1f);
    endtask
    // the whole sequence runs back to back, no other access can slip in between
    task automatic flash_op(input logic [31:0] ctrl, input logic [14:0] ad);
        unlock();
        bus(1'b1, `FSC_IDX_CTRL, ctrl);
        bus(1'b1, `FSC_IDX_XADDR, {17'h0, ad});
        e = 16'($random(seed)) & 16'h00ff;
        bus(1'b1, `FSC_IDX_XDATA, {16'h0, e});
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        seed = 72;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h0);
        bus(1'b0, `FSC_IDX_CR, 0); chk(r, 32'h10);
        bus(1'b0, `FSC_IDX_DIN, 0); chk(r, 32'h0);
        bus(1'b0, 16'h0100, 0); chk(r, 32'h0);
        bus(1'b1, `FSC_IDX_KEY, 32'h5a);
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h1);
        bus(1'b1, `FSC_IDX_KEY, 32'h1f);
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h3);
        bus(1'b1, `FSC_IDX_CTRL, 32'h21);
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h0);
        for (int k = 0; k < 2; k++) begin
            fail_req <= k[0];
            slow <= k[0];
            a = 15'($random(seed)) & 15'h3fff;
            flash_op(32'h21, a);
            chk(i_flash.wr_cnt, k + 1);
            chk({17'h0, i_flash.last_addr}, {17'h0, a});
            chk({24'h0, i_flash.last_data}, {16'h0, e});
            bus(1'b0, `FSC_IDX_CTRL, 0); chk(r & 32'h10, k ? 32'h10 : 32'h0);
        end
        fail_req <= 1'b0;
        flash_op(32'h26, 15'h0800);
        chk(i_flash.pre_cnt + i_flash.ers_cnt, 0);
        flash_op(32'h05, 15'h0800);
        chk(i_flash.pre_cnt, 0);
        flash_op(32'h25, 15'h1a34);
        chk(i_flash.pre_cnt, 1);
        chk({17'h0, i_flash.last_addr}, 32'h1800);
        flash_op(32'h25, 15'h7a00);
        flash_op(32'h23, 15'h7a00);
        chk(i_flash.ers_cnt, 7);
        chk(32'(w >= ERASE_N), 1);
        flash_op(32'h25, 15'h1000);
        flash_op(32'h23, 15'h1000);
        chk(i_flash.ers_cnt, 15);
        chk(i_flash.wr_cnt, 2);
        bus(1'b1, `FSC_IDX_KEY, 32'h1f);
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h2);
        unlock();
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h2);
        // second reset, with the sequencer idle, must clear the frozen state
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        bus(1'b0, `FSC_IDX_STATE, 0); chk(r, 32'h0);
        for (int v = 0; v < 2; v++) begin
            bus(1'b1, `FSC_IDX_CR, v ? 32'h0c : 32'h08);
            e = v ? 16'hffff : 16'h0000;
            for (int n = 0; n < 6; n++) begin
                a = 15'($random(seed));
                bus(1'b1, `FSC_IDX_DIN, {24'h0, a[7:0]});
                e = crc8(e, a[7:0]);
            end
            bus(1'b1, `FSC_IDX_CR, 32'h01 | (v << 2));
            bus(1'b0, `FSC_IDX_DR, 0); chk(r, {24'h0, e[15:8]});
            bus(1'b1, `FSC_IDX_CR, 32'h00 | (v << 2));
            bus(1'b0, `FSC_IDX_DR, 0); chk(r, {24'h0, e[7:0]});
        end
        bus(1'b1, `FSC_IDX_CR, 32'h01);
        bus(1'b1, `FSC_IDX_DR, 32'h12);
        bus(1'b1, `FSC_IDX_CR, 32'h00);
        bus(1'b1, `FSC_IDX_DR, 32'h34);
        bus(1'b1, `FSC_IDX_DIN, 32'h5c);
        e = crc8(16'h1234, 8'h5c);
        bus(1'b0, `FSC_IDX_DR, 0); chk(r, {24'h0, e[7:0]});
        for (int t = 0; t < 3; t++) begin
            bus(1'b1, `FSC_IDX_CR, 32'h0c);
            bus(1'b1, `FSC_IDX_BEG, {25'h0, beg_t[t]});
            bus(1'b1, `FSC_IDX_CNT, {25'h0, cnt_t[t]});
            bus(1'b1, `FSC_IDX_CR, 32'h06);
            e = 16'hffff;
            for (int b = beg_t[t] * 256; b < ((beg_t[t] + cnt_t[t] > 127) ? 128 :
                    beg_t[t] + cnt_t[t] + 1) * 256; b++) begin
                a = 15'(b);
                e = crc8(e, a[7:0] ^ {a[14:8], 1'b1});
            end
            bus(1'b0, `FSC_IDX_CR, 0); chk(r & 32'h10, 32'h10);
            bus(1'b1, `FSC_IDX_CR, 32'h05);
            bus(1'b0, `FSC_IDX_DR, 0); chk(r, {24'h0, e[15:8]});
            bus(1'b1, `FSC_IDX_CR, 32'h04);
            bus(1'b0, `FSC_IDX_DR, 0); chk(r, {24'h0, e[7:0]});
        end
        conclude();
    end
endmodule
